// [rtl/cec_map.vh]
// Register map, field positions and reset values for the comparator event control block
`ifndef CEC_MAP_VH
`define CEC_MAP_VH

// APB byte address of the control/status register
`define CEC_CTRL_ADDR 12'h000
`define CEC_ADDR_W 12

// Field positions inside the control/status register
`define CEC_BIT_POWER_OFF 7
`define CEC_BIT_REF_SEL 6
`define CEC_BIT_RESULT 5
`define CEC_BIT_IRQ_FLAG 4
`define CEC_BIT_IRQ_EN 3
`define CEC_BIT_CAPTURE 2
`define CEC_BIT_EDGE_HI 1
`define CEC_BIT_EDGE_LO 0

// Edge-select codes
`define CEC_EDGE_TOGGLE 2'h0
`define CEC_EDGE_RESERVED 2'h1
`define CEC_EDGE_FALL 2'h2
`define CEC_EDGE_RISE 2'h3

// Reset values
`define CEC_RESET_BIT 1'h0
`define CEC_RESET_EDGE 2'h0
`define CEC_RESET_DATA 32'h0000_0000

`endif

// [rtl/cec_sync.v]
// Two-flop synchroniser for the comparator output
`timescale 1ns/1ps
module cec_sync (
   // Clock and reset
   input wire clk,
   input wire resetn,
   // Data
   input wire din,
   output wire dout
);
   reg stage1_reg;
   reg stage2_reg;

   // First stage feeds only the second stage
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         stage1_reg <= 1'h0;
         stage2_reg <= 1'h0;
      end else begin
         stage1_reg <= din;
         stage2_reg <= stage1_reg;
      end
   end

   assign dout = stage2_reg;
endmodule

// [rtl/cec_top.v]
// Comparator event control: APB register, edge detection, interrupt flag, capture routing
`timescale 1ns/1ps
`include "cec_map.vh"
module cec_top (
   // Clock and reset
   input wire clk,
   input wire resetn,
   // APB slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] paddr,
   input wire [31:0] pwdata,
   input wire [3:0] pstrb,
   output wire pready,
   output wire pslverr,
   output reg [31:0] prdata,
   // Analog comparator core
   input wire compare_raw,
   output wire compare_power_off,
   output wire reference_input_select,
   // Processor side
   input wire processor_global_irq_enable,
   input wire irq_vector_ack,
   output wire compare_irq,
   // Brownout detector fuse
   input wire brownout_fuse,
   // Timer input capture front end
   output wire capture_trigger,
   output wire capture_route_enable
);
   reg power_off_reg;
   reg ref_sel_reg;
   reg irq_flag_reg;
   reg irq_en_reg;
   reg capture_reg;
   reg [1:0] edge_sel_reg;
   reg result_prev_reg;
   wire result_sync;
   wire access;
   wire hit;
   wire wr_hit;
   wire rd_setup;
   wire [7:0] status_byte;
   wire flag_set;
   wire flag_clear;
   reg event_hit;
   reg power_off_next;
   reg ref_sel_next;
   reg irq_en_next;
   reg capture_next;
   reg [1:0] edge_sel_next;
   reg irq_flag_next;
   reg [31:0] prdata_next;

   // Synchronise the asynchronous comparator output
   cec_sync u_sync (
      .clk(clk),
      .resetn(resetn),
      .din(compare_raw),
      .dout(result_sync)
   );

   // APB decode; every access completes with no wait state
   assign access = psel & penable;
   assign hit = (paddr[`CEC_ADDR_W-1:0] == `CEC_CTRL_ADDR) && (paddr[31:`CEC_ADDR_W] == 20'h00000);
   // Only the low byte lane carries control bits, so its strobe gates a write
   assign wr_hit = access & pwrite & hit & pstrb[0];
   // A read is prepared in its setup cycle, so the word stands at the completing edge
   assign rd_setup = psel & ~penable & ~pwrite & hit;
   // No wait state: the register answers in the first access cycle
   assign pready = 1'h1;
   // Unmapped addresses answer with an error so software sees a bad pointer
   assign pslverr = access & ~hit;

   // Status byte as software sees it.
   // The result bit is the synchronised sample, two clocks behind the pin,
   // which keeps the read value and the event logic in agreement.
   assign status_byte = {power_off_reg, ref_sel_reg, result_sync, irq_flag_reg,
                         irq_en_reg, capture_reg, edge_sel_reg};

   // Next read word; bits above the control byte always read as zero
   always @* begin
      prdata_next = prdata;
      if (rd_setup) begin
         prdata_next = {24'h000000, status_byte};
      end
   end

   // Read data loaded at the end of the setup cycle.
   // Trade-off: the word is one cycle older than the completing edge,
   // bought so that the data output comes straight from flip-flops.
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         prdata <= `CEC_RESET_DATA;
      end else begin
         prdata <= prdata_next;
      end
   end

   // Next values of the writable control bits.
   // Unmapped writes and writes without the low strobe leave them alone.
   always @* begin
      power_off_next = power_off_reg;
      ref_sel_next = ref_sel_reg;
      irq_en_next = irq_en_reg;
      capture_next = capture_reg;
      edge_sel_next = edge_sel_reg;
      if (wr_hit) begin
         power_off_next = pwdata[`CEC_BIT_POWER_OFF];
         ref_sel_next = pwdata[`CEC_BIT_REF_SEL];
         irq_en_next = pwdata[`CEC_BIT_IRQ_EN];
         capture_next = pwdata[`CEC_BIT_CAPTURE];
         edge_sel_next = {pwdata[`CEC_BIT_EDGE_HI], pwdata[`CEC_BIT_EDGE_LO]};
      end
   end

   // Writable control bits.
   // Limitation: the block does not guard power or edge changes itself;
   // software must drop the interrupt enable first or a stray event may raise compare_irq; the flag still sets.
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         power_off_reg <= `CEC_RESET_BIT;
         ref_sel_reg <= `CEC_RESET_BIT;
         irq_en_reg <= `CEC_RESET_BIT;
         capture_reg <= `CEC_RESET_BIT;
         edge_sel_reg <= `CEC_RESET_EDGE;
      end else begin
         power_off_reg <= power_off_next;
         ref_sel_reg <= ref_sel_next;
         irq_en_reg <= irq_en_next;
         capture_reg <= capture_next;
         edge_sel_reg <= edge_sel_next;
      end
   end

   // Previous synchronised sample for edge detection
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         result_prev_reg <= 1'h0;
      end else begin
         result_prev_reg <= result_sync;
      end
   end

   // Event decode by edge-select code
   always @* begin
      case (edge_sel_reg)
         `CEC_EDGE_TOGGLE: event_hit = result_sync ^ result_prev_reg;
         `CEC_EDGE_FALL: event_hit = ~result_sync & result_prev_reg;
         `CEC_EDGE_RISE: event_hit = result_sync & ~result_prev_reg;
         `CEC_EDGE_RESERVED: event_hit = 1'h0;
         default: event_hit = 1'h0;
      endcase
   end

   // Flag set and clear conditions
   assign flag_set = event_hit;
   // A write of one clears it, so read-modify-write of other bits clears it too
   assign flag_clear = irq_vector_ack | (wr_hit & pwdata[`CEC_BIT_IRQ_FLAG]);

   // Next flag value; a new event wins over a clear in the same cycle,
   // so an event that lands while the handler is entered is never lost
   always @* begin
      irq_flag_next = irq_flag_reg;
      if (flag_set) begin
         irq_flag_next = 1'h1;
      end else if (flag_clear) begin
         irq_flag_next = 1'h0;
      end
   end

   // Interrupt flag register
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         irq_flag_reg <= `CEC_RESET_BIT;
      end else begin
         irq_flag_reg <= irq_flag_next;
      end
   end

   // Interrupt request gated by local and global enables
   assign compare_irq = irq_flag_reg & irq_en_reg & processor_global_irq_enable;

   // Analog controls
   assign compare_power_off = power_off_reg;
   // Reference only when brownout detection is fused on
   assign reference_input_select = ref_sel_reg & brownout_fuse;

   // Capture routing; disconnected path held low
   assign capture_route_enable = capture_reg;
   assign capture_trigger = capture_reg & result_sync;
endmodule

// [dv/cec_chk_monitor.sv]
// Port checker for the comparator event control block
`timescale 1ns/1ps
module cec_chk (
   input wire logic clk, resetn, psel, penable, pwrite, compare_raw, compare_irq,
   input wire logic [31:0] paddr, pwdata,
   input wire logic [3:0] pstrb,
   input wire logic compare_power_off, reference_input_select, brownout_fuse,
   input wire logic processor_global_irq_enable, irq_vector_ack,
   input wire logic capture_trigger, capture_route_enable);
   // Completing write to the control register
   wire wr = psel && penable && pwrite && paddr == 32'h0 && pstrb[0];
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   // No comparator event can still be in the synchroniser
   sequence s_calm; $stable(compare_raw) [*5]; endsequence
   a_power_bit: assert property (wr |=> compare_power_off == $past(pwdata[7]))
      else $error("power bit");
   a_ref_gate: assert property (reference_input_select |-> brownout_fuse)
      else $error("ref gate");
   a_route_bit: assert property (wr |=> capture_route_enable == $past(pwdata[2]))
      else $error("route bit");
   a_route_off: assert property (!capture_route_enable |-> !capture_trigger)
      else $error("route off");
   a_sync_route: assert property (compare_raw [*4] ##0 capture_route_enable |-> capture_trigger)
      else $error("route sync");
   a_irq_gate: assert property (compare_irq |-> processor_global_irq_enable)
      else $error("irq gate");
   a_w1c_clear: assert property (s_calm ##0 wr && pwdata[4] |=> !compare_irq)
      else $error("w1c");
   a_ack_clear: assert property (s_calm ##0 irq_vector_ack |=> !compare_irq)
      else $error("ack");
endmodule

// [dv/cec_cmp_model.sv]
// Behavioural analog comparator core
`timescale 1ns/1ps
module cec_cmp_model #(parameter int REF_MV = 1220) (
   input wire logic power_off, ref_sel,
   input var int pos_mv, neg_mv,
   output logic out);
   // Off core rests low so a stale high never leaks out
   assign out = !power_off && (ref_sel ? REF_MV : pos_mv) > neg_mv;
endmodule

// [dv/cec_top_tb_top.sv]
// Bench for the comparator event control block
`timescale 1ns/1ps
module cec_top_tb_top;
   logic clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, irq_vector_ack = 0;
   logic processor_global_irq_enable = 1, brownout_fuse = 0, compare_raw;
   logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
   logic err;
   logic [3:0] pstrb = 4'h1;
   logic pready, pslverr, compare_power_off, reference_input_select, compare_irq;
   logic capture_trigger, capture_route_enable;
   wire [3:0] outs = {compare_power_off, reference_input_select, capture_route_enable,
      capture_trigger};
   int pos = 0, fails = 0, n_tests = 0, cyc = 0;
   cec_top cec_top_i (.*);
   cec_cmp_model cec_cmp_model_i (.power_off(compare_power_off),
      .ref_sel(reference_input_select), .pos_mv(pos), .neg_mv(500), .out(compare_raw));
   task chk(input logic [31:0] g, e);
      n_tests++;
      if (g !== e) begin
         fails++;
         $display("wrong value at %0t: %h not %h", $time, g, e);
      end
   endtask
   // One APB transfer; data and error taken at the edge that sees pready high
   task apb(input logic w, input logic [31:0] a, d);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk) penable <= 1;
      do @(posedge clk); while (pready !== 1);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge clk);
   endtask
   task report_and_stop;
      $display("%0d checks, %0d wrong", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial forever #25 clk = ~clk;
   // Hang guard, far above the roughly 150 cycles needed
   always @(posedge clk) if (++cyc == 2000) begin fails++; report_and_stop; end
   initial begin
      repeat (5) @(posedge clk);
      resetn <= 1;
      apb(0, 0, 0);
      chk(rd, 32'h0);
      // Rise then fall per edge code, enable held off while the code changes
      for (int c = 0; c < 4; c++) begin
         apb(1, 0, 32'h10 | c);
         pos <= 900;
         repeat (6) @(posedge clk);
         apb(0, 0, 0);
         chk(rd, 32'h20 | c | (c % 3 == 0 ? 32'h10 : 32'h0));
         apb(1, 0, 32'h10 | c);
         pos <= 0;
         repeat (6) @(posedge clk);
         apb(0, 0, 0);
         chk(rd, c | (c % 2 == 0 ? 32'h10 : 32'h0));
      end
      $display("edge test done");
      apb(1, 0, 32'h1b);
      pos <= 900;
      repeat (6) @(posedge clk);
      chk(compare_irq, 32'h1);
      processor_global_irq_enable <= 0;
      @(posedge clk);
      chk(compare_irq, 32'h0);
      processor_global_irq_enable <= 1;
      irq_vector_ack <= 1;
      @(posedge clk) irq_vector_ack <= 0;
      @(posedge clk);
      chk(compare_irq, 32'h0);
      pos <= 0;
      repeat (6) @(posedge clk);
      pos <= 900;
      repeat (6) @(posedge clk);
      apb(1, 0, 32'h1b);
      chk(compare_irq, 32'h0);
      $display("irq test done");
      apb(1, 0, 32'h03);
      brownout_fuse <= 1;
      apb(1, 0, 32'hc5);
      repeat (4) @(posedge clk);
      apb(0, 0, 0);
      chk(rd, 32'hc5);
      chk(outs, 4'he);
      brownout_fuse <= 0;
      apb(1, 0, 32'h45);
      apb(1, 32'h100, 32'h0);
      chk(err, 1'b1);
      apb(0, 0, 0);
      chk(rd, 32'h65);
      chk(outs, 4'h3);
      $display("route test done");
      report_and_stop;
   end
endmodule
bind cec_top cec_chk cec_chk_i (.*);
